// file: inc/nhf_pkg.sv
package nhf_pkg;
  // bus cycle kinds
  typedef enum logic [1:0] {
    NHF_CYC_CMD,
    NHF_CYC_ADDR,
    NHF_CYC_WDATA,
    NHF_CYC_RDATA
  } nhf_cyc_e;

  // one host request: a single bus cycle, or five address cycles when sent with req_addr_go
  typedef struct packed {
    nhf_cyc_e    kind;   // cycle type
    logic [15:0] data;   // command, address byte or data word
  } nhf_req_s;

  // structured array address
  typedef struct packed {
    logic [11:0] column; // byte or word position
    logic [5:0]  page;   // page within block
    logic [18:0] block;  // block, plane and die bits
  } nhf_addr_s;

  // address layout
  localparam int NHF_ADDR_CYCLES   = 5;
  localparam int NHF_PAGE_BITS     = 6;
  localparam int NHF_PLANE_BIT     = 6;
  localparam int NHF_DIE_BIT       = 18;
  localparam int NHF_COL_HI_X8     = 11;
  localparam int NHF_COL_HI_X16    = 10;
  localparam int NHF_COL_ZLO_X8    = 6;
  localparam int NHF_COL_ZLO_X16   = 5;

  // status commands a busy die still accepts
  localparam logic [7:0] NHF_CMD_STATUS     = 8'h70;
  localparam logic [7:0] NHF_CMD_STATUS_ENH = 8'h78;

  // strobe phase timing in clock cycles (100 ns each)
  localparam int NHF_SETUP_NS     = 100;
  localparam int NHF_PULSE_NS     = 100;
  localparam int NHF_HOLD_NS      = 100;
  localparam int NHF_CLK_NS       = 100;
  localparam int NHF_SETUP_CYC    = (NHF_SETUP_NS + NHF_CLK_NS - 1) / NHF_CLK_NS;
  localparam int NHF_PULSE_CYC    = (NHF_PULSE_NS + NHF_CLK_NS - 1) / NHF_CLK_NS;
  localparam int NHF_HOLD_CYC     = (NHF_HOLD_NS + NHF_CLK_NS - 1) / NHF_CLK_NS;
  localparam logic [3:0] NHF_CNT_RESET = 4'h0;
endpackage : nhf_pkg

// file: logic/nhf_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - commands, addresses only on low byte lane
// - upper lane zero during command cycles
// - command, then addresses, then data cycles
// - five address bytes: two column, three row
// - x8: column bit 11 clears bits 10:6
// - x16: column bit 10 clears bits 9:5
// - chip select goes high the cycle after an idle cycle with no request taken, busy or not
// - unused address bits driven low
module nhf_host_ctrl
  import nhf_pkg::*;
#(
  parameter bit X16 = 1'b0           // 16-bit bus variant
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // request side
  input  wire nhf_req_s    req,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire nhf_addr_s   req_addr,   // used for address sequences
  input  wire logic        req_addr_go, // with kind ADDR: send all five bytes
  input  wire logic        busy_ok,     // permit non-status command while busy
  // read data out
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic             cmd_refused, // high every cycle a command is held back while busy
  // flash pins
  output logic             chip_sel_n,
  output logic             cmd_latch,
  output logic             addr_latch,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             write_prot_n,
  input  wire logic        wp_enable,
  input  wire logic [15:0] io_in,
  output logic      [15:0] io_out,
  output logic      [15:0] io_oe,
  input  wire logic        ready_busy_n
);
  typedef enum logic [2:0] {
    NHF_IDLE, NHF_SETUP, NHF_PULSE, NHF_HOLD
  } nhf_state_e;

  nhf_state_e  st_reg, st_next;          // strobe phase
  logic [3:0]  cnt_reg, cnt_next;        // phase timer
  nhf_cyc_e    kind_reg, kind_next;      // current cycle type
  logic [15:0] dat_reg, dat_next;        // driven word
  logic [2:0]  abyte_reg, abyte_next;    // address byte index
  logic        aseq_reg, aseq_next;      // address sequence running
  nhf_addr_s   addr_reg, addr_next;      // held address
  logic        cs_reg, cs_next;          // chip select asserted
  logic [15:0] cap_reg, cap_next;        // captured read word
  logic        cap_v_reg, cap_v_next;    // capture push
  logic        buf_ready;                // buffer can take a word
  logic        is_status;                // command allowed while busy

  // pack one address byte from the structured address
  function automatic logic [7:0] addr_byte(input nhf_addr_s a, input logic [2:0] idx);
    logic [11:0] col;
    col = a.column;
    if (!X16 && col[NHF_COL_HI_X8]) col[NHF_COL_HI_X8-1:NHF_COL_ZLO_X8] = '0;
    if (X16 && col[NHF_COL_HI_X16]) col[NHF_COL_HI_X16-1:NHF_COL_ZLO_X16] = '0;
    if (X16) col[11] = 1'b0;
    unique case (idx)
      3'h0:    addr_byte = col[7:0];
      3'h1:    addr_byte = {4'h0, col[11:8]};
      3'h2:    addr_byte = {a.block[7:6], a.page};
      3'h3:    addr_byte = a.block[15:8];
      3'h4:    addr_byte = {5'h00, a.block[NHF_DIE_BIT:16]};
      default: addr_byte = 8'h00;
    endcase
  endfunction : addr_byte

  assign is_status = (req.data[7:0] == NHF_CMD_STATUS) || (req.data[7:0] == NHF_CMD_STATUS_ENH);

  // take a request only when idle and, for reads, when the buffer has room
  assign req_ready = (st_reg == NHF_IDLE) && !aseq_reg &&
                     !(req.kind == NHF_CYC_RDATA && !buf_ready) &&
                     !(req.kind == NHF_CYC_CMD && !ready_busy_n && !is_status && !busy_ok);

  // sequencing of one bus cycle at a time
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    kind_next  = kind_reg;
    dat_next   = dat_reg;
    abyte_next = abyte_reg;
    aseq_next  = aseq_reg;
    addr_next  = addr_reg;
    cs_next    = cs_reg;
    cap_next   = cap_reg;
    cap_v_next = 1'b0;
    cmd_refused = req_valid && (st_reg == NHF_IDLE) && !aseq_reg && req.kind == NHF_CYC_CMD &&
                  !ready_busy_n && !is_status && !busy_ok;
    unique case (st_reg)
      NHF_IDLE: begin
        if (aseq_reg) begin
          // next address byte of the sequence
          kind_next = NHF_CYC_ADDR;
          dat_next  = {8'h00, addr_byte(addr_reg, abyte_reg)};
          st_next   = NHF_SETUP;
          cnt_next  = NHF_CNT_RESET;
          cs_next   = 1'b1;
        end else if (req_valid && req_ready) begin
          kind_next = req.kind;
          cs_next   = 1'b1;
          st_next   = NHF_SETUP;
          cnt_next  = NHF_CNT_RESET;
          unique case (req.kind)
            NHF_CYC_CMD: begin
              dat_next   = {8'h00, req.data[7:0]};
              abyte_next = 3'h0;
            end
            NHF_CYC_ADDR: begin
              if (req_addr_go) begin
                addr_next  = req_addr;
                aseq_next  = 1'b1;
                abyte_next = 3'h1;
                dat_next   = {8'h00, addr_byte(req_addr, 3'h0)};
              end else begin
                dat_next   = {8'h00, req.data[7:0]};
              end
            end
            NHF_CYC_WDATA: dat_next = X16 ? req.data : {8'h00, req.data[7:0]};
            NHF_CYC_RDATA: dat_next = 16'h0000;
          endcase
        end else begin
          cs_next = 1'b0;
        end
      end
      NHF_SETUP: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(NHF_SETUP_CYC - 1)) begin
          st_next  = NHF_PULSE;
          cnt_next = NHF_CNT_RESET;
        end
      end
      NHF_PULSE: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(NHF_PULSE_CYC - 1)) begin
          st_next  = NHF_HOLD;
          cnt_next = NHF_CNT_RESET;
          if (kind_reg == NHF_CYC_RDATA) begin
            cap_next   = X16 ? io_in : {8'h00, io_in[7:0]};
            cap_v_next = 1'b1;
          end
        end
      end
      NHF_HOLD: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(NHF_HOLD_CYC - 1)) begin
          st_next  = NHF_IDLE;
          cnt_next = NHF_CNT_RESET;
          if (aseq_reg) begin
            if (abyte_reg == 3'(NHF_ADDR_CYCLES)) aseq_next = 1'b0;
            else abyte_next = abyte_reg + 3'h1;
            if (abyte_reg == 3'(NHF_ADDR_CYCLES)) abyte_next = 3'h0;
          end
        end
      end
      default: st_next = NHF_IDLE;
    endcase
    // stop sequence after last byte is issued
    if (st_reg == NHF_IDLE && aseq_reg && abyte_reg == 3'(NHF_ADDR_CYCLES)) begin
      aseq_next = 1'b0;
      st_next   = NHF_IDLE;
      cs_next   = 1'b0;
      abyte_next = 3'h0;
    end else if (st_reg == NHF_IDLE && aseq_reg) begin
      abyte_next = abyte_reg + 3'h1;
    end
    if (st_reg == NHF_HOLD) abyte_next = abyte_reg;
  end

  // pin drive from phase state
  always_comb begin
    chip_sel_n     = !cs_reg;
    cmd_latch      = cs_reg && kind_reg == NHF_CYC_CMD && st_reg != NHF_IDLE;
    addr_latch     = cs_reg && kind_reg == NHF_CYC_ADDR && st_reg != NHF_IDLE;
    write_strobe_n = !(st_reg == NHF_PULSE && kind_reg != NHF_CYC_RDATA);
    read_strobe_n  = !(st_reg == NHF_PULSE && kind_reg == NHF_CYC_RDATA);
    write_prot_n   = wp_enable;
    io_out         = dat_reg;
    io_oe          = (st_reg != NHF_IDLE && kind_reg != NHF_CYC_RDATA) ?
                     (X16 ? 16'hFFFF : 16'h00FF) : 16'h0000;
  end

  // register stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg    <= NHF_IDLE;
      cnt_reg   <= NHF_CNT_RESET;
      kind_reg  <= NHF_CYC_CMD;
      dat_reg   <= 16'h0000;
      abyte_reg <= 3'h0;
      aseq_reg  <= 1'b0;
      addr_reg  <= '0;
      cs_reg    <= 1'b0;
      cap_reg   <= 16'h0000;
      cap_v_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      kind_reg  <= kind_next;
      dat_reg   <= dat_next;
      abyte_reg <= abyte_next;
      aseq_reg  <= aseq_next;
      addr_reg  <= addr_next;
      cs_reg    <= cs_next;
      cap_reg   <= cap_next;
      cap_v_reg <= cap_v_next;
    end
  end

  // read words wait here for the consumer
  nhf_skid_buf #(.WIDTH(16)) u_rbuf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_data   (cap_reg),
    .in_valid  (cap_v_reg),
    .in_ready  (buf_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );

  cmd_upper_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_latch |-> io_out[15:8] == 8'h00) else $error("upper lane not zero on command");
  addr_low_lane_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_latch |-> io_out[15:8] == 8'h00) else $error("address off low lane");
  latch_exclusive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(cmd_latch && addr_latch)) else $error("both latches high");
  strobe_needs_cs_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!write_strobe_n || !read_strobe_n) |-> !chip_sel_n) else $error("strobe in standby");
  strobe_not_both_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(!write_strobe_n && !read_strobe_n)) else $error("both strobes low");
  busy_cmd_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_refused |=> st_reg == NHF_IDLE) else $error("refused command started a cycle");
  x8_col_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!X16 && addr_latch && aseq_reg && abyte_reg == 3'h2 && st_reg == NHF_PULSE && io_out[3])
      |-> (io_out[2:0] == 3'h0 && $past(io_out[7:6], 4) == 2'h0)) else $error("column guard bits set");
  wr_pulse_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(write_strobe_n) |=> write_strobe_n) else $error("write pulse too long");
endmodule : nhf_host_ctrl
`default_nettype wire

// file: logic/nhf_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer, valid/ready on both sides
module nhf_skid_buf
  import nhf_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_reg [2];   // storage
  logic [WIDTH-1:0] mem0_next;     // next entry 0
  logic [WIDTH-1:0] mem1_next;     // next entry 1
  logic             wp_reg;        // write slot
  logic             wp_next;
  logic             rp_reg;        // read slot
  logic             rp_next;
  logic [1:0]       cnt_reg;       // occupancy
  logic [1:0]       cnt_next;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and storage updates
  always_comb begin
    mem0_next = mem_reg[0];
    mem1_next = mem_reg[1];
    if (push && !wp_reg) begin
      mem0_next = in_data;
    end
    if (push && wp_reg) begin
      mem1_next = in_data;
    end
    wp_next  = push ? ~wp_reg : wp_reg;
    rp_next  = pop ? ~rp_reg : rp_reg;
    cnt_next = cnt_reg + 2'(push) - 2'(pop);
  end

  // register stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else begin
      wp_reg     <= wp_next;
      rp_reg     <= rp_next;
      cnt_reg    <= cnt_next;
      mem_reg[0] <= mem0_next;
      mem_reg[1] <= mem1_next;
    end
  end

  stall_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("stalled word lost");
endmodule : nhf_skid_buf
`default_nettype wire

// file: sim/nand_async_bus_front_end_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); end end
module nand_async_bus_front_end_test
  import nhf_pkg::*;
;
  logic ref_clk, rst_n, req_valid, req_ready, req_addr_go, busy_ok, rd_valid, rd_ready, cmd_refused;
  logic chip_sel_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, write_prot_n, wp_enable;
  logic ready_busy_n, hold_busy, taken, refused;
  nhf_req_s    req;        // request word
  nhf_addr_s   req_addr;   // address for sequences
  logic [15:0] rd_data, io_in, io_out, io_oe;
  logic [15:0] got_q [$];  // words handed out
  logic [7:0]  wbytes [4]; // written data bytes
  int          miscompares, total_checks, base;
  nhf_host_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_addr_go(req_addr_go), .busy_ok(busy_ok), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .cmd_refused(cmd_refused), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .write_prot_n(write_prot_n), .wp_enable(wp_enable), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .ready_busy_n(ready_busy_n));
  nhf_flash_model flash (.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n),
    .host_out(io_out), .host_oe(io_oe), .hold_busy(hold_busy), .io_line(io_in), .ready_busy_n(ready_busy_n));
  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // collect every word the buffer hands out
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) got_q.push_back(rd_data);
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // hold one request up to bound cycles, note refusal pulses
  task automatic request(input nhf_cyc_e k, input logic [15:0] d, input int bound);
    int n;
    @(posedge ref_clk);
    #10;
    req = '{kind: k, data: d};
    req_addr_go = (k == NHF_CYC_ADDR);
    req_valid = 1'b1;
    refused = 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (cmd_refused === 1'b1) refused = 1'b1;
    end while (req_ready !== 1'b1 && n < bound);
    taken = (req_ready === 1'b1);
    #10;
    req_valid = 1'b0;
    req_addr_go = 1'b0;
  endtask : request
  // request that must be taken, then wait until the pins are idle
  task automatic send(input nhf_cyc_e k, input logic [15:0] d);
    int n;
    request(k, d, 200);
    n = 0;
    while ((chip_sel_n !== 1'b1 && n < 200) || n < 2) begin
      @(posedge ref_clk);
      n++;
    end
    #10;
    if (!taken || n >= 200) begin
      miscompares++;
      final_report();
    end
  endtask : send
  // expected address byte i for the five byte sequence
  function automatic logic [7:0] exp_byte(input nhf_addr_s a, input int i);
    logic [11:0] col;
    col = a.column;
    if (col[11]) col[10:6] = 5'h00;
    case (i)
      0: return col[7:0];
      1: return {4'h0, col[11:8]};
      2: return {a.block[7:6], a.page};
      3: return a.block[15:8];
      default: return {5'h00, a.block[18:16]};
    endcase
  endfunction : exp_byte
  initial begin
    miscompares = 0;
    total_checks = 0;
    void'($urandom(32'h3517911e));
    {rst_n, req_valid, req_addr_go, busy_ok, hold_busy} = 5'h00;
    {rd_ready, wp_enable} = 2'h3;
    req = '0;
    req_addr = '0;
    repeat (3) @(posedge ref_clk);
    #10;
    rst_n = 1'b1;
    `CHECK({chip_sel_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n}, 5'h13)
    `CHECK(io_oe, 16'h0000)
    $display("test reset done");
    // command cycles, fixed codes and random ones
    for (int i = 0; i < 6; i++) begin
      logic [7:0] c;
      c = (i < 3) ? 8'h00 + 8'h7F * 8'(i) : 8'($urandom());
      base = flash.cmd_cnt;
      send(NHF_CYC_CMD, {8'h00, c});
      `CHECK(flash.cmd_reg, c)
      `CHECK(flash.cmd_cnt, base + 1)
    end
    $display("test commands done");
    // address sequences, column guard corner first
    for (int i = 0; i < 4; i++) begin
      req_addr.column = (i == 0) ? 12'hFC5 : 12'($urandom());
      req_addr.page = 6'($urandom());
      req_addr.block = (i == 1) ? 19'h40040 : 19'($urandom());
      send(NHF_CYC_CMD, 16'h0000);
      send(NHF_CYC_ADDR, 16'h0000);
      `CHECK(flash.addr_idx, NHF_ADDR_CYCLES)
      for (int b = 0; b < 5; b++) `CHECK(flash.addr_byte[b], exp_byte(req_addr, b))
      `CHECK({flash.die_sel, flash.plane_sel}, {req_addr.block[18], req_addr.block[6]})
    end
    $display("test addresses done");
    // write four bytes, read back with the receiver stalled
    send(NHF_CYC_CMD, 16'h0080);
    send(NHF_CYC_ADDR, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wbytes[i] = 8'($urandom());
      send(NHF_CYC_WDATA, {8'h00, wbytes[i]});
      `CHECK(flash.cache_reg[i][7:0], wbytes[i])
    end
    send(NHF_CYC_CMD, 16'h0000);
    send(NHF_CYC_ADDR, 16'h0000);
    got_q.delete();
    rd_ready = 1'b0;
    send(NHF_CYC_RDATA, 16'h0000);
    send(NHF_CYC_RDATA, 16'h0000);
    request(NHF_CYC_RDATA, 16'h0000, 10);
    `CHECK(taken, 1'b0)
    rd_ready = 1'b1;
    send(NHF_CYC_RDATA, 16'h0000);
    send(NHF_CYC_RDATA, 16'h0000);
    `CHECK(got_q.size(), 4)
    for (int i = 0; i < 4 && i < got_q.size(); i++) `CHECK(got_q[i][7:0], wbytes[i])
    $display("test data path done");
    // busy die: status commands go out, others held back unless busy_ok
    hold_busy = 1'b1;
    base = flash.cmd_cnt;
    request(NHF_CYC_CMD, 16'h0060, 10);
    `CHECK({taken, refused}, 2'h1)
    `CHECK(flash.cmd_cnt, base)
    for (int i = 0; i < 2; i++) begin
      wp_enable = i[0];
      send(NHF_CYC_CMD, i ? 16'h0078 : 16'h0070);
      `CHECK(flash.cmd_reg, i ? 8'h78 : 8'h70)
      `CHECK(write_prot_n, wp_enable)
      got_q.delete();
      send(NHF_CYC_RDATA, 16'h0000);
      `CHECK(got_q.size(), 1)
      if (got_q.size() > 0) `CHECK(got_q[0][7:0], {wp_enable, 7'h00})
    end
    busy_ok = 1'b1;
    request(NHF_CYC_CMD, 16'h0060, 20);
    `CHECK(taken, 1'b1)
    {busy_ok, hold_busy} = 2'h0;
    $display("test busy done");
    `CHECK(flash.stray_cnt, 0)
    `CHECK(flash.lane_err, 0)
    final_report();
  end
endmodule : nand_async_bus_front_end_test
`default_nettype wire

// file: sim/nhf_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural flash die driven only by its pin edges
module nhf_flash_model (
  input  wire logic        chip_sel_n,
  input  wire logic        cmd_latch,
  input  wire logic        addr_latch,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_prot_n,
  input  wire logic [15:0] host_out,     // host drive value
  input  wire logic [15:0] host_oe,      // host drive enables
  input  wire logic        hold_busy,    // bench keeps the die busy
  output logic      [15:0] io_line,      // resolved bus level
  output logic             ready_busy_n
);
  logic [7:0]  cmd_reg;         // last accepted command
  int          cmd_cnt;         // accepted commands
  logic [7:0]  addr_byte [5];   // latched address bytes
  int          addr_idx;        // address byte counter
  logic [15:0] cache_reg [16];  // one page slice, data and cache as one
  int          wr_ptr;          // write word position
  int          rd_ptr;          // read word position
  int          lane_err;        // upper lane seen nonzero
  int          stray_cnt;       // write strobes seen in standby
  logic        status_mode;     // reads return the status byte
  logic [15:0] drive_val;       // value put on the bus
  logic        drive_on;        // die drives the bus
  logic        plane_sel;       // decoded plane
  logic        die_sel;         // decoded die, 0 is lower half
  logic        ws_low;          // write strobe really went low
  // released lines show the inverse of the last driven value
  assign io_line = (host_oe & host_out) | (~host_oe & (drive_on ? drive_val : ~drive_val));
  assign ready_busy_n = ~hold_busy;
  assign plane_sel = addr_byte[2][6];
  assign die_sel = addr_byte[4][2];
  initial begin
    cmd_cnt = 0;
    addr_idx = 0;
    wr_ptr = 0;
    rd_ptr = 0;
    lane_err = 0;
    stray_cnt = 0;
    status_mode = 1'b0;
    drive_val = 16'h0000;
    drive_on = 1'b0;
    ws_low = 1'b0;
  end
  // only a true low level arms the next rise
  always @(negedge write_strobe_n) ws_low = (write_strobe_n === 1'b0);
  // command, address and data capture on strobe rise
  always @(posedge write_strobe_n) begin
    if (!ws_low) begin
      // a rise out of an unknown level is not a strobe
    end else if (chip_sel_n) begin
      stray_cnt++;
    end else if (read_strobe_n) begin
      if (cmd_latch) begin
        if ((host_oe[15:8] & host_out[15:8]) !== 8'h00 || host_oe[7:0] !== 8'hFF) lane_err++;
        if (!hold_busy || io_line[7:0] == 8'h70 || io_line[7:0] == 8'h78) begin
          cmd_reg = io_line[7:0];
          cmd_cnt++;
          addr_idx = 0;
          wr_ptr = 0;
          rd_ptr = 0;
          status_mode = (io_line[7:0] == 8'h70 || io_line[7:0] == 8'h78);
        end
      end else if (addr_latch) begin
        if ((host_oe[15:8] & host_out[15:8]) !== 8'h00 || host_oe[7:0] !== 8'hFF) lane_err++;
        if (addr_idx < 5) addr_byte[addr_idx] = io_line[7:0];
        addr_idx++;
      end else if (!hold_busy) begin
        cache_reg[wr_ptr % 16] = io_line;
        wr_ptr++;
      end
    end
    ws_low = 1'b0;
  end
  // read data or status on strobe fall, held until deselect
  always @(negedge read_strobe_n) begin
    if (!chip_sel_n && !cmd_latch && !addr_latch && write_strobe_n) begin
      drive_val = status_mode ? {8'h00, write_prot_n, ~hold_busy, 6'h00} : cache_reg[rd_ptr % 16];
      drive_on = 1'b1;
      if (!status_mode) rd_ptr++;
    end
  end
  always @(posedge chip_sel_n) drive_on = 1'b0;
endmodule : nhf_flash_model
`default_nettype wire
